/* rtl/viu_event_arbiter.sv */
// Vectored interrupt and exception arbiter facing the processor core
// Functional notes
// - Accept and arbitrate 49 requests: two non-maskable plus 47 maskable.
// - Pin edge gives code 0010H; watchdog overflow gives code 0020H, handler 00000020H.
// - Reset from pin or internal source uses code 0000H, handler 0, no return.
// - Trap vectors 0-15 give 004nH at 40H, vectors 16-31 give 005nH at 50H.
// - Bad opcode or debug trap gives 0060H, returning to following instruction.
// - Eight external and thirty-nine internal maskable requests are supported.
// - Each maskable request has one of eight programmable levels plus default order.
// - Each maskable request has a mask; masked requests are never offered.
// - Higher level pending request may preempt a lower level handler in service.
// - Pins are filtered and edge detected with a per-pin edge choice.
// - Pin 0 has code 0090H; each later pin adds 10H to code and handler.
// - Each timer channel has its own vector, first channel 0120H at priority 10.
// - Clocked serial 0 receive or error and two-wire 1 done share 0290H.
// - Async serial 2 receive and two-wire 0 done share 0350H.
// - Equal level ties go to the lowest default priority number.
// - Simultaneous watchdog and pin non-maskable requests: watchdog wins, pin dropped.
`timescale 1ns/1ns
`default_nettype none
module viu_event_arbiter (
    input  wire logic                                      mclk,
    input  wire logic                                      sys_rst,
    input  wire logic [viu_pkg::N_EXT-1:0]                 ext_pin,
    input  wire logic [2*viu_pkg::N_EXT-1:0]               ext_edge_sel,
    input  wire logic                                      nmi_pin,
    input  wire logic [1:0]                                nmi_edge_sel,
    input  wire logic                                      watchdog_overflow_request,
    input  wire logic                                      internal_reset_req,
    input  wire logic [viu_pkg::N_INT-1:0]                 periph_req,
    input  wire logic                                      serial_clk0_rx_err_req,
    input  wire logic                                      two_wire1_done_request,
    input  wire logic                                      two_wire0_done_request,
    input  wire logic [viu_pkg::N_MASK-1:0]                mask,
    input  wire logic [viu_pkg::N_MASK-1:0][viu_pkg::LVL_W-1:0] level,
    input  wire logic                                      trap_req,
    input  wire logic [4:0]                                trap_vec,
    input  wire logic                                      bad_opcode_trap,
    input  wire logic                                      debug_trap_instruction,
    input  wire logic [31:0]                               following_instr_addr,
    input  wire logic                                      core_int_en,
    input  wire logic                                      nonmask_active_flag,
    input  wire logic                                      core_ack,
    input  wire logic                                      core_eoi,
    output var  logic                                      grant_valid_q,
    output var  viu_pkg::viu_vec_s                         grant_q,
    output var  logic [viu_pkg::N_MASK-1:0]                pending_q,
    output var  logic [viu_pkg::N_LVL-1:0]                 in_service_q
);

    logic [viu_pkg::N_EXT:0]   pin_pulse;
    logic [viu_pkg::N_MASK-1:0] mreq;
    logic                      rst_pend_q;
    logic                      wdt_pend_q;
    logic                      nmi_pend_q;
    logic                      trap_pend_q;
    logic [15:0]               trap_code_q;
    logic [31:0]               trap_handler_q;
    logic [31:0]               trap_ret_q;
    viu_pkg::viu_src_e         sel_q;
    logic [5:0]                sel_idx_q;
    viu_pkg::viu_lvl_t         sel_lvl_q;
    logic                      best_found;
    logic [5:0]                best_idx;
    logic [viu_pkg::LVL_W:0]   best_lvl;
    logic [viu_pkg::LVL_W:0]   ceil_lvl;
    logic [viu_pkg::N_LVL-1:0] pop_mask;
    logic                      ack_rst;
    logic                      ack_wdt;
    logic                      ack_nmi;
    logic                      ack_trap;
    logic                      ack_mask;

    // Pins 0..7 and the non-maskable pin share one filter block
    viu_pin_filter #(
        .W (viu_pkg::N_EXT + 1)
    ) u_pin_filter (
        .mclk     (mclk),
        .sys_rst  (sys_rst),
        .pin_in   ({nmi_pin, ext_pin}),
        .edge_sel ({nmi_edge_sel, ext_edge_sel}),
        .pulse_q  (pin_pulse)
    );

    // Request map: index 0 internal, 1..8 pins, rest internal
    genvar k;
    generate
        for (k = 0; k < viu_pkg::N_MASK; k++) begin : g_map
            if (k >= viu_pkg::EXT_FIRST && k < viu_pkg::EXT_FIRST + viu_pkg::N_EXT) begin : g_ext
                assign mreq[k] = pin_pulse[k - viu_pkg::EXT_FIRST];
            end else if (k == 0) begin : g_first
                assign mreq[k] = periph_req[0];
            end else if (k - viu_pkg::N_EXT == viu_pkg::INT_SHARE_A) begin : g_sha
                assign mreq[k] = periph_req[k - viu_pkg::N_EXT] | serial_clk0_rx_err_req
                               | two_wire1_done_request;
            end else if (k - viu_pkg::N_EXT == viu_pkg::INT_SHARE_B) begin : g_shb
                assign mreq[k] = periph_req[k - viu_pkg::N_EXT]
                               | two_wire0_done_request;
            end else begin : g_int
                assign mreq[k] = periph_req[k - viu_pkg::N_EXT];
            end
        end
    endgenerate

    assign ack_rst  = core_ack & grant_valid_q & (sel_q == viu_pkg::SRC_RST);
    assign ack_wdt  = core_ack & grant_valid_q & (sel_q == viu_pkg::SRC_WDT);
    assign ack_nmi  = core_ack & grant_valid_q & (sel_q == viu_pkg::SRC_NMI);
    assign ack_trap = core_ack & grant_valid_q & (sel_q == viu_pkg::SRC_TRAP);
    assign ack_mask = core_ack & grant_valid_q & (sel_q == viu_pkg::SRC_MASK);

    // Best unmasked pending request; strict compare keeps lowest index on ties
    always_comb begin
        best_found = 1'b0;
        best_idx   = 6'h00;
        best_lvl   = viu_pkg::LVL_NONE;
        for (int i = 0; i < viu_pkg::N_MASK; i++) begin
            if (pending_q[i] && !mask[i] && ({1'b0, level[i]} < best_lvl)) begin
                best_found = 1'b1;
                best_idx   = 6'(i);
                best_lvl   = {1'b0, level[i]};
            end
        end
    end

    // Highest level now in service and the bit a return removes
    always_comb begin
        ceil_lvl = viu_pkg::LVL_NONE;
        pop_mask = 8'h00;
        for (int i = viu_pkg::N_LVL - 1; i >= 0; i--) begin
            if (in_service_q[i]) begin
                ceil_lvl = 4'(i);
                pop_mask = 8'(1 << i);
            end
        end
    end

    // Reset request, also raised by internal reset sources
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            rst_pend_q <= viu_pkg::RST_PEND_INIT;
        end else if (internal_reset_req) begin
            rst_pend_q <= 1'b1;
        end else if (ack_rst) begin
            rst_pend_q <= 1'b0;
        end
    end

    // Non-maskable requests; watchdog beats a simultaneous pin edge
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            wdt_pend_q <= 1'b0;
            nmi_pend_q <= 1'b0;
        end else begin
            if (watchdog_overflow_request) begin
                wdt_pend_q <= 1'b1;
            end else if (ack_wdt) begin
                wdt_pend_q <= 1'b0;
            end
            if (pin_pulse[viu_pkg::N_EXT] && !watchdog_overflow_request) begin
                nmi_pend_q <= 1'b1;
            end else if (ack_nmi) begin
                nmi_pend_q <= 1'b0;
            end
        end
    end

    // Software trap and exception trap capture
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            trap_pend_q    <= 1'b0;
            trap_code_q    <= viu_pkg::CODE_RESET;
            trap_handler_q <= 32'h00000000;
            trap_ret_q     <= 32'h00000000;
        end else if (bad_opcode_trap || debug_trap_instruction) begin
            trap_pend_q    <= 1'b1;
            trap_code_q    <= viu_pkg::CODE_BADOP;
            trap_handler_q <= {16'h0000, viu_pkg::CODE_BADOP};
            trap_ret_q     <= following_instr_addr;
        end else if (trap_req) begin
            trap_pend_q    <= 1'b1;
            trap_code_q    <= (trap_vec[4] ? viu_pkg::CODE_TRAP_HI : viu_pkg::CODE_TRAP_LO)
                            | {12'h000, trap_vec[3:0]};
            trap_handler_q <= {16'h0000, trap_vec[4] ? viu_pkg::CODE_TRAP_HI
                                                     : viu_pkg::CODE_TRAP_LO};
            trap_ret_q     <= following_instr_addr;
        end else if (ack_trap) begin
            trap_pend_q    <= 1'b0;
        end
    end

    // Maskable pending flags; a new request beats the acknowledge clear
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            pending_q <= '0;
        end else begin
            for (int i = 0; i < viu_pkg::N_MASK; i++) begin
                if (mreq[i]) begin
                    pending_q[i] <= 1'b1;
                end else if (ack_mask && (sel_idx_q == 6'(i))) begin
                    pending_q[i] <= 1'b0;
                end
            end
        end
    end

    // Levels in service: return pops the highest, acknowledge pushes
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            in_service_q <= 8'h00;
        end else begin
            in_service_q <= (in_service_q & ~(core_eoi ? pop_mask : 8'h00))
                          | (ack_mask ? 8'(1 << sel_lvl_q) : 8'h00);
        end
    end

    // Grant offered to the core, rebuilt every cycle until acknowledged
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            grant_valid_q <= 1'b0;
            grant_q       <= '0;
            sel_q         <= viu_pkg::SRC_NONE;
            sel_idx_q     <= 6'h00;
            sel_lvl_q     <= '0;
        end else if (core_ack) begin
            grant_valid_q <= 1'b0;
            sel_q         <= viu_pkg::SRC_NONE;
        end else if (rst_pend_q) begin
            grant_valid_q <= 1'b1;
            sel_q         <= viu_pkg::SRC_RST;
            grant_q       <= '{code: viu_pkg::CODE_RESET, handler: 32'h00000000,
                               ret_valid: 1'b0, ret_addr: 32'h00000000};
        end else if (wdt_pend_q && !nonmask_active_flag) begin
            grant_valid_q <= 1'b1;
            sel_q         <= viu_pkg::SRC_WDT;
            grant_q       <= '{code: viu_pkg::CODE_WDT, handler: {16'h0000, viu_pkg::CODE_WDT},
                               ret_valid: 1'b1, ret_addr: following_instr_addr};
        end else if (nmi_pend_q && !nonmask_active_flag) begin
            grant_valid_q <= 1'b1;
            sel_q         <= viu_pkg::SRC_NMI;
            grant_q       <= '{code: viu_pkg::CODE_NMI, handler: {16'h0000, viu_pkg::CODE_NMI},
                               ret_valid: 1'b1, ret_addr: following_instr_addr};
        end else if (trap_pend_q) begin
            grant_valid_q <= 1'b1;
            sel_q         <= viu_pkg::SRC_TRAP;
            grant_q       <= '{code: trap_code_q, handler: trap_handler_q,
                               ret_valid: 1'b1, ret_addr: trap_ret_q};
        end else if (core_int_en && best_found && (best_lvl < ceil_lvl)) begin
            grant_valid_q <= 1'b1;
            sel_q         <= viu_pkg::SRC_MASK;
            sel_idx_q     <= best_idx;
            sel_lvl_q     <= best_lvl[viu_pkg::LVL_W-1:0];
            grant_q       <= '{code: viu_pkg::mask_code(int'(best_idx)),
                               handler: {16'h0000, viu_pkg::mask_code(int'(best_idx))},
                               ret_valid: 1'b1, ret_addr: following_instr_addr};
        end else begin
            grant_valid_q <= 1'b0;
            sel_q         <= viu_pkg::SRC_NONE;
        end
    end

endmodule // viu_event_arbiter
`default_nettype wire

/* rtl/viu_pin_filter.sv */
// Pin synchroniser, noise filter and selectable edge detector
`timescale 1ns/1ns
`default_nettype none
module viu_pin_filter #(
    parameter int W = 9
) (
    input  wire logic           mclk,
    input  wire logic           sys_rst,
    input  wire logic [W-1:0]   pin_in,
    input  wire logic [2*W-1:0] edge_sel,
    output var  logic [W-1:0]   pulse_q
);

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_pin
            logic s1_q;
            logic s2_q;
            logic s3_q;
            logic filt_q;
            logic [1:0] sel;

            assign sel = edge_sel[2*i +: 2];

            always_ff @(posedge mclk or posedge sys_rst) begin
                if (sys_rst) begin
                    s1_q <= 1'b0;
                    s2_q <= 1'b0;
                    s3_q <= 1'b0;
                end else begin
                    s1_q <= pin_in[i];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                end
            end

            // Level accepted only when two stages agree
            always_ff @(posedge mclk or posedge sys_rst) begin
                if (sys_rst) begin
                    filt_q <= 1'b0;
                end else if (s2_q == s3_q) begin
                    filt_q <= s3_q;
                end
            end

            always_ff @(posedge mclk or posedge sys_rst) begin
                if (sys_rst) begin
                    pulse_q[i] <= 1'b0;
                end else begin
                    unique case (sel)
                        viu_pkg::EDGE_RISE: pulse_q[i] <= (s2_q == s3_q) & s3_q & ~filt_q;
                        viu_pkg::EDGE_FALL: pulse_q[i] <= (s2_q == s3_q) & ~s3_q & filt_q;
                        viu_pkg::EDGE_BOTH: pulse_q[i] <= (s2_q == s3_q) & (s3_q ^ filt_q);
                        viu_pkg::EDGE_NONE: pulse_q[i] <= 1'b0;
                    endcase
                end
            end
        end
    endgenerate

endmodule // viu_pin_filter
`default_nettype wire

/* rtl/viu_pkg.sv */
// Constants, types and helpers shared by the interrupt and exception unit
package viu_pkg;

    localparam int N_MASK = 47;
    localparam int N_EXT  = 8;
    localparam int N_INT  = 39;
    localparam int N_LVL  = 8;
    localparam int LVL_W  = 3;

    // Mask index of the first external pin request
    localparam int EXT_FIRST = 1;
    // Internal request inputs that carry a shared vector
    localparam int INT_SHARE_A = 19;
    localparam int INT_SHARE_B = 29;

    // Gaps in the default priority numbering
    localparam int PRIO_GAP1_END = 22;
    localparam int PRIO_GAP1     = 6;
    localparam int PRIO_GAP2_END = 32;
    localparam int PRIO_GAP2     = 8;

    localparam logic [15:0] CODE_RESET     = 16'h0000;
    localparam logic [15:0] CODE_NMI       = 16'h0010;
    localparam logic [15:0] CODE_WDT       = 16'h0020;
    localparam logic [15:0] CODE_TRAP_LO   = 16'h0040;
    localparam logic [15:0] CODE_TRAP_HI   = 16'h0050;
    localparam logic [15:0] CODE_BADOP     = 16'h0060;
    localparam logic [15:0] CODE_MASK_BASE = 16'h0080;
    localparam logic [15:0] CODE_STEP      = 16'h0010;

    localparam logic [1:0] EDGE_NONE = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;

    // Ceiling value when no level is in service
    localparam logic [LVL_W:0] LVL_NONE = 4'h8;

    localparam logic RST_PEND_INIT = 1'b1;

    typedef logic [LVL_W-1:0] viu_lvl_t;

    typedef enum logic [5:0] {
        SRC_NONE = 6'h01,
        SRC_RST  = 6'h02,
        SRC_WDT  = 6'h04,
        SRC_NMI  = 6'h08,
        SRC_TRAP = 6'h10,
        SRC_MASK = 6'h20
    } viu_src_e;

    typedef struct packed {
        logic [15:0] code;
        logic [31:0] handler;
        logic        ret_valid;
        logic [31:0] ret_addr;
    } viu_vec_s;

    // Exception code of a maskable source from its index
    function automatic logic [15:0] mask_code(input int k);
        int prio;
        prio = (k <= PRIO_GAP1_END) ? k :
               (k <= PRIO_GAP2_END) ? k + PRIO_GAP1 : k + PRIO_GAP2;
        return CODE_MASK_BASE + 16'(prio) * CODE_STEP;
    endfunction

endpackage

/* test/viu_core_model.sv */
// Processor core model that takes and acknowledges grants
`timescale 1ns/1ns
`default_nettype none
module viu_core_model (
    input  wire logic              mclk,
    input  wire logic              sys_rst,
    input  wire logic              grant_valid_q,
    input  wire viu_pkg::viu_vec_s grant_q,
    input  wire logic [3:0]        ack_dly,
    output var  logic              core_ack,
    output var  logic              took,
    output var  viu_pkg::viu_vec_s took_vec
);
    logic [3:0] cnt;

    // Acknowledge at an instruction boundary after ack_dly waits
    always @(negedge mclk) begin
        if (sys_rst || core_ack) begin
            core_ack = 1'b0;
            cnt = 4'h0;
        end else if (grant_valid_q && cnt >= ack_dly) begin
            core_ack = 1'b1;
        end else begin
            cnt = grant_valid_q ? cnt + 4'h1 : 4'h0;
        end
    end

    // Record what was shown at the acknowledge edge
    always @(posedge mclk) begin
        took <= core_ack && grant_valid_q;
        took_vec <= grant_q;
    end
endmodule // viu_core_model
`default_nettype wire

/* test/viu_event_arbiter_sva.sv */
// Checker of grant behaviour at the arbiter ports
`timescale 1ns/1ns
`default_nettype none
module viu_event_arbiter_sva (
    input wire logic                       mclk,
    input wire logic                       sys_rst,
    input wire logic                       watchdog_overflow_request,
    input wire logic                       internal_reset_req,
    input wire logic                       bad_opcode_trap,
    input wire logic [31:0]                following_instr_addr,
    input wire logic                       nonmask_active_flag,
    input wire logic                       core_ack,
    input wire logic                       core_eoi,
    input wire logic [viu_pkg::N_MASK-1:0] mask,
    input wire logic                       grant_valid_q,
    input wire viu_pkg::viu_vec_s          grant_q,
    input wire logic [viu_pkg::N_LVL-1:0]  in_service_q
);
    default clocking @(posedge mclk);
    endclocking
    default disable iff (sys_rst);
    wire logic mk = grant_valid_q && grant_q.code >= 16'h0080;

    reset_grant_a: assert property (
        $past(sys_rst) |=> grant_valid_q && grant_q.code == 16'h0000)
        else $error("no reset grant after release");
    reset_vector_a: assert property (
        grant_valid_q && grant_q.code == 16'h0000 |-> !grant_q.ret_valid && grant_q.handler == 32'h0)
        else $error("reset grant carries return or handler");
    handler_zext_a: assert property (
        grant_valid_q && grant_q.code[15:5] != 11'h002 |-> grant_q.handler == {16'h0, grant_q.code})
        else $error("handler differs from code");
    trap_handler_a: assert property (
        grant_valid_q && grant_q.code[15:5] == 11'h002
        |-> grant_q.handler == {16'h0, grant_q.code[15:4], 4'h0})
        else $error("trap handler wrong");
    ack_drop_a: assert property (
        grant_valid_q && core_ack |=> !grant_valid_q)
        else $error("grant stays after acknowledge");
    wdt_grant_a: assert property (
        (watchdog_overflow_request && !nonmask_active_flag && !core_ack && !internal_reset_req
         && !$past(internal_reset_req) && !(grant_valid_q && grant_q.code == 16'h0000))
        ##1 (!core_ack && !nonmask_active_flag && !internal_reset_req)
        |=> grant_valid_q && grant_q.code == 16'h0020)
        else $error("watchdog grant missing");
    bad_opcode_a: assert property (
        (bad_opcode_trap && nonmask_active_flag && !grant_valid_q && !core_ack
         && !internal_reset_req && !$past(internal_reset_req))
        ##1 (nonmask_active_flag && !core_ack && !internal_reset_req)
        |=> grant_valid_q && grant_q.code == 16'h0060 && grant_q.ret_valid
            && grant_q.ret_addr == $past(following_instr_addr, 2))
        else $error("bad opcode grant wrong");
    mask_block_a: assert property (
        (&mask) [*2] |=> !mk)
        else $error("masked request offered");
    level_ceiling_a: assert property (
        in_service_q[0] [*2] |=> !mk)
        else $error("request offered above ceiling");
    level_push_a: assert property (
        mk && core_ack && !core_eoi |=> in_service_q != 8'h00)
        else $error("in service level not recorded");

    cover property (mk && core_ack);
    cover property (grant_valid_q && grant_q.code == 16'h0020);
    cover property (in_service_q == 8'h21);
endmodule // viu_event_arbiter_sva

bind viu_event_arbiter viu_event_arbiter_sva i_sva (
    .mclk(mclk), .sys_rst(sys_rst), .watchdog_overflow_request(watchdog_overflow_request),
    .internal_reset_req(internal_reset_req), .bad_opcode_trap(bad_opcode_trap),
    .following_instr_addr(following_instr_addr), .nonmask_active_flag(nonmask_active_flag),
    .core_ack(core_ack), .core_eoi(core_eoi), .mask(mask), .grant_valid_q(grant_valid_q),
    .grant_q(grant_q), .in_service_q(in_service_q)
);
`default_nettype wire

/* test/viu_event_arbiter_tb.sv */
// Self-checking bench for the interrupt and exception arbiter
`timescale 1ns/1ns
`default_nettype none
module viu_event_arbiter_tb;
    logic              mclk, sys_rst, nmi_pin, wdt, irst, rx_err, tw1, tw0, trap_req;
    logic              badop, dbg, int_en, np, eoi, core_ack, took, gv;
    logic [7:0]        ext_pin, insv;
    logic [15:0]       ext_sel;
    logic [1:0]        nmi_sel;
    logic [38:0]       preq;
    logic [46:0]       mask, pend;
    logic [46:0][2:0]  level;
    logic [4:0]        trap_vec;
    logic [31:0]       nia;
    logic [3:0]        ack_dly;
    viu_pkg::viu_vec_s gq, tv;
    logic [15:0]       cd [6];
    int                bad_count, checks;

    viu_event_arbiter i_dut (
        .mclk(mclk), .sys_rst(sys_rst), .ext_pin(ext_pin), .ext_edge_sel(ext_sel),
        .nmi_pin(nmi_pin), .nmi_edge_sel(nmi_sel), .watchdog_overflow_request(wdt),
        .internal_reset_req(irst), .periph_req(preq), .serial_clk0_rx_err_req(rx_err),
        .two_wire1_done_request(tw1), .two_wire0_done_request(tw0), .mask(mask),
        .level(level), .trap_req(trap_req), .trap_vec(trap_vec), .bad_opcode_trap(badop),
        .debug_trap_instruction(dbg), .following_instr_addr(nia), .core_int_en(int_en),
        .nonmask_active_flag(np), .core_ack(core_ack), .core_eoi(eoi), .grant_valid_q(gv),
        .grant_q(gq), .pending_q(pend), .in_service_q(insv)
    );
    viu_core_model i_core (
        .mclk(mclk), .sys_rst(sys_rst), .grant_valid_q(gv), .grant_q(gq), .ack_dly(ack_dly),
        .core_ack(core_ack), .took(took), .took_vec(tv)
    );

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Next falling edge; one-cycle pulses drop
    task automatic tick();
        @(negedge mclk);
        {wdt, irst, rx_err, tw1, tw0, trap_req, badop, dbg, eoi} = 9'h000;
        preq = 39'h0;
    endtask

    // Wait for the core to take a grant, compare it, optionally end its handler
    task automatic grab(input logic [15:0] code, input logic pop);
        int n;
        logic [31:0] hnd;
        hnd = (code[15:5] == 11'h002) ? {16'h0, code[15:4], 4'h0} : {16'h0, code};
        for (n = 0; n < 80 && took !== 1'b1; n++) begin
            tick();
        end
        if (n == 80) begin
            bad_count++;
            test_done();
        end
        chk(64'({tv.code, tv.handler}), 64'({code, hnd}));
        eoi = pop;
        tick();
    endtask

    task automatic quiet(input int cyc);
        int k, hits;
        hits = 0;
        for (k = 0; k < cyc; k++) begin
            tick();
            hits += (took === 1'b1);
        end
        chk(64'(hits), 64'h0);
    endtask

    initial begin
        cd = '{16'h0120, 16'h0290, 16'h0290, 16'h0290, 16'h0350, 16'h0350};
        sys_rst = 1'b1;
        {nmi_pin, int_en, np} = 3'h2;
        {wdt, irst, rx_err, tw1, tw0, trap_req, badop, dbg, eoi} = 9'h000;
        preq = 39'h0;
        ext_pin = 8'h00;
        ext_sel = {8{viu_pkg::EDGE_RISE}};
        nmi_sel = viu_pkg::EDGE_RISE;
        mask = 47'h0;
        level = '0;
        trap_vec = 5'h00;
        nia = 32'h0000_2468;
        ack_dly = 4'h0;
        bad_count = 0;
        checks = 0;
        repeat (4) @(posedge mclk);
        @(negedge mclk);
        sys_rst = 1'b0;
        grab(16'h0000, 1'b0);
        irst = 1'b1;
        grab(16'h0000, 1'b0);
        wdt = 1'b1;
        grab(16'h0020, 1'b0);
        nmi_pin = 1'b1;
        grab(16'h0010, 1'b0);
        nmi_sel = viu_pkg::EDGE_BOTH;
        nmi_pin = 1'b0;
        repeat (4) tick();
        wdt = 1'b1;
        grab(16'h0020, 1'b0);
        quiet(6);
        for (int v = 0; v < 32; v++) begin
            trap_vec = 5'(v);
            trap_req = 1'b1;
            grab(16'h0040 + 16'(v), 1'b0);
        end
        np = 1'b1;
        badop = 1'b1;
        grab(16'h0060, 1'b0);
        chk(64'({tv.ret_valid, tv.ret_addr}), 64'({1'b1, nia}));
        dbg = 1'b1;
        grab(16'h0060, 1'b0);
        wdt = 1'b1;
        quiet(6);
        np = 1'b0;
        grab(16'h0020, 1'b0);
        for (int i = 0; i < 8; i++) begin
            ext_pin[i] = 1'b1;
            grab(16'h0090 + 16'(16 * i), 1'b1);
        end
        ext_sel = {8{viu_pkg::EDGE_FALL}};
        ext_pin = 8'h00;
        for (int i = 0; i < 8; i++) begin
            grab(16'h0090 + 16'(16 * i), 1'b1);
        end
        ext_sel = {8{viu_pkg::EDGE_NONE}};
        ext_pin[0] = 1'b1;
        quiet(10);
        for (int k = 0; k < 6; k++) begin
            case (k)
                0: preq[2] = 1'b1;
                1: preq[19] = 1'b1;
                2: rx_err = 1'b1;
                3: tw1 = 1'b1;
                4: preq[29] = 1'b1;
                default: tw0 = 1'b1;
            endcase
            grab(cd[k], 1'b1);
        end
        mask = {47{1'b1}};
        preq[3] = 1'b1;
        quiet(8);
        chk(64'(pend[11]), 64'h1);
        mask = 47'h0;
        int_en = 1'b0;
        quiet(4);
        int_en = 1'b1;
        grab(16'h0130, 1'b1);
        ack_dly = 4'h3;
        preq[4:3] = 2'h3;
        grab(16'h0130, 1'b1);
        grab(16'h0140, 1'b1);
        level[11] = 3'h1;
        preq[4:3] = 2'h3;
        grab(16'h0140, 1'b1);
        grab(16'h0130, 1'b1);
        ack_dly = 4'h0;
        level[11] = 3'h5;
        level[13] = 3'h6;
        preq[3] = 1'b1;
        grab(16'h0130, 1'b0);
        preq[4] = 1'b1;
        grab(16'h0140, 1'b0);
        preq[5] = 1'b1;
        quiet(10);
        chk(64'(insv), 64'h21);
        eoi = 1'b1;
        tick();
        eoi = 1'b1;
        grab(16'h0150, 1'b1);
        test_done();
    end
endmodule // viu_event_arbiter_tb
`default_nettype wire
